// ==== src/pmsr_shutdown_vid_regs.sv ====
// Shutdown-cause flags and step-down regulator voltage-ID registers behind the serial port.
// Assumes shutdown causes and sleep pins arrive asynchronously; the pin select strap is static.
//
// Summary of operation
// - Hardware sets the three shutdown flags; host clears each by writing one.
// - Supply undervoltage shutdown sets the undervoltage flag.
// - Unmasked rail power fault shutdown sets the power-fault flag.
// - Critical die temperature shutdown sets the critical-temperature flag.
// - Any of those flags being set also raises the shutdown indicator.
// - Regulator two voltage code lives in bits 7..1, reset 28h, read-write.
// - Voltage codes map to 10 mV or 25 mV step output ranges.
// - Regulator two decay bit chooses controlled slew (0) or free decay (1).
// - Regulator three decay register bit 0 gives the same slew or decay choice.
// - Regulator three decay bits 7..1 are read-write, reset 38h, no effect.
// - Regulator three voltage code lives in bits 7..1, reset 38h; bit 0 reserved.
// - Regulator three sleep code is copied to its voltage code on sleep entry.
// - Sleep enable allows the sleep change; a strapped pin choice triggers it.
`timescale 1ns/1ps
`default_nettype none
module pmsr_shutdown_vid_regs
   import pmsr_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEFAULT
) (
   // Clock and reset.
   input  wire logic       ref_clk_in,
   input  wire logic       rst_in,
   // Serial register port, open drain.
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   output logic            sda_out,
   output logic            sda_oe_out,
   // Shutdown causes from the supervisory circuits.
   input  wire logic       supply_undervoltage_flag_shutdown_in,
   input  wire logic       power_fault_shutdown_in,
   input  wire logic       crit_temp_shutdown_in,
   // Sleep control pins and the factory pin choice.
   input  wire logic       sleep_control_pin_a_in,
   input  wire logic       sleep_control_pin_b_in,
   input  wire logic       sleep_pin_select_in,
   // Indicator towards the interrupt register.
   output logic            shutdown_indicator_set_out,
   // Regulator controls.
   output logic [6:0]      reg2_voltage_code_out,
   output logic            reg2_decay_select_out,
   output logic [6:0]      reg3_voltage_code_out,
   output logic            reg3_decay_select_out
);

   typedef struct packed {
      logic [2:0] evt_s1;
      logic [2:0] evt_s2;
      logic [1:0] slp_s1;
      logic [1:0] slp_s2;
      logic       slp_q;
      logic       sel_s1;
      logic       sel_s2;
      logic [1:0] sel_fill;
      logic       sel_cap;
      logic       sel_done;
      logic [2:0] flags;
      logic       shdn_set;
      logic [7:0] reg2;
      logic [7:0] r3dec;
      logic [7:0] r3vid;
      logic [7:0] r3slp;
   } pmsr_regs_q_t;

   pmsr_regs_q_t q_ff;
   pmsr_regs_q_t nxt_q;
   logic [7:0]   ptr;
   logic         wr_stb;
   logic [7:0]   wr_data;
   logic [7:0]   rd_data;
   logic         sleep_lvl;
   logic         sleep_entry;
   logic         wr_shdn;
   logic [2:0]   clr_mask;
   logic [2:0]   w1c_exp;
   logic         sda_low_ff;

   // Read view of the register file; unmapped offsets return a fixed value.
   function automatic logic [7:0] reg_read(input logic [7:0] addr, input pmsr_regs_q_t s);
      logic [7:0] v;
      v = READ_UNMAPPED;
      case (addr)
         ADDR_SHUTDOWN: begin
            v[FLAG_SUPPLY_UNDERVOLTAGE_FLAG:FLAG_CTEMP] = s.flags;
            v[FLAG_COLD_OFF]        = 1'b0;
         end
         ADDR_REG2_CTRL:  v = s.reg2;
         ADDR_REG3_DECAY: v = s.r3dec;
         ADDR_REG3_VID:   v = s.r3vid;
         ADDR_REG3_SLEEP: v = s.r3slp;
         default:         v = READ_UNMAPPED;
      endcase
      return v;
   endfunction

   pmsr_i2c_slave #(
      .DEV_ADDR    (DEV_ADDR)
   ) u_port (
      .ref_clk_in  (ref_clk_in),
      .rst_in      (rst_in),
      .scl_in      (scl_in),
      .sda_in      (sda_in),
      .sda_oe_out  (sda_oe_out),
      .rd_data_in  (rd_data),
      .ptr_out     (ptr),
      .wr_stb_out  (wr_stb),
      .wr_data_out (wr_data)
   );

   // Decodes shared by the next-state logic and the checks.
   assign rd_data     = reg_read(ptr, q_ff);
   assign wr_shdn     = wr_stb && (ptr == ADDR_SHUTDOWN);
   assign clr_mask    = wr_shdn ? wr_data[FLAG_SUPPLY_UNDERVOLTAGE_FLAG:FLAG_CTEMP] : 3'h0;
   assign w1c_exp     = clr_mask & ~q_ff.evt_s2;
   assign sleep_lvl   = q_ff.sel_cap ? q_ff.slp_s2[1] : q_ff.slp_s2[0];
   assign sleep_entry = sleep_lvl & ~q_ff.slp_q;

   // Next state of flags, regulator registers and synchronisers.
   always_comb begin
      nxt_q        = q_ff;
      nxt_q.evt_s1 = {supply_undervoltage_flag_shutdown_in, power_fault_shutdown_in, crit_temp_shutdown_in};
      nxt_q.evt_s2 = q_ff.evt_s1;
      nxt_q.slp_s1 = {sleep_control_pin_b_in, sleep_control_pin_a_in};
      nxt_q.slp_s2 = q_ff.slp_s1;
      nxt_q.slp_q  = sleep_lvl;
      // The strap passes two flops, then is caught once so a later glitch cannot swap the pin.
      nxt_q.sel_s1   = sleep_pin_select_in;
      nxt_q.sel_s2   = q_ff.sel_s1;
      nxt_q.sel_fill = {q_ff.sel_fill[0], 1'b1};
      // Waiting for the fill keeps the reset value of the second flop out of the capture.
      if (q_ff.sel_fill[1] && !q_ff.sel_done) begin
         nxt_q.sel_cap  = q_ff.sel_s2;
         nxt_q.sel_done = 1'b1;
      end
      // A cause that is present in the clearing cycle keeps its flag set.
      nxt_q.flags    = (q_ff.flags & ~clr_mask) | q_ff.evt_s2;
      nxt_q.shdn_set = |(q_ff.evt_s2 & ~q_ff.flags);
      if (wr_stb) begin
         case (ptr)
            ADDR_REG2_CTRL:  nxt_q.reg2  = wr_data;
            ADDR_REG3_DECAY: nxt_q.r3dec = wr_data;
            ADDR_REG3_VID:   nxt_q.r3vid = wr_data;
            ADDR_REG3_SLEEP: nxt_q.r3slp = wr_data;
            default:         nxt_q.r3slp = q_ff.r3slp;
         endcase
      end
      // Sleep entry overrides a simultaneous host write to the voltage code.
      if (sleep_entry && q_ff.r3slp[CTRL_BIT]) begin
         nxt_q.r3vid[CODE_MSB:CODE_LSB] = q_ff.r3slp[CODE_MSB:CODE_LSB];
      end
   end

   // State register with reset values.
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         q_ff       <= '0;
         q_ff.flags <= RST_SHUTDOWN_FLAGS;
         q_ff.reg2  <= RST_REG2_CTRL;
         q_ff.r3dec <= RST_REG3_DECAY;
         q_ff.r3vid <= RST_REG3_VID;
         q_ff.r3slp <= RST_REG3_SLEEP;
         sda_low_ff <= 1'b0;
      end else begin
         q_ff       <= nxt_q;
         sda_low_ff <= 1'b0;
      end
   end

   // The regulator decodes each code into its 10 mV or 25 mV step range.
   assign reg2_voltage_code_out      = q_ff.reg2[CODE_MSB:CODE_LSB];
   assign reg2_decay_select_out      = q_ff.reg2[CTRL_BIT];
   assign reg3_voltage_code_out      = q_ff.r3vid[CODE_MSB:CODE_LSB];
   assign reg3_decay_select_out      = q_ff.r3dec[CTRL_BIT];
   assign shutdown_indicator_set_out = q_ff.shdn_set;
   assign sda_out                    = sda_low_ff;

   // Checks on the register behaviour.
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (rst_in);

   w1c_clear_a: assert property (w1c_exp != 3'h0 |=> (q_ff.flags & $past(w1c_exp)) == 3'h0)
      else $error("Shutdown flag not cleared by write of one.");
   cold_off_zero_a: assert property (ptr == ADDR_SHUTDOWN |-> rd_data[7:3] == 5'h00)
      else $error("Cold-off or reserved shutdown bits read nonzero.");
   supply_undervoltage_flag_set_a: assert property ($rose(q_ff.evt_s2[FLAG_SUPPLY_UNDERVOLTAGE_FLAG]) |=> q_ff.flags[FLAG_SUPPLY_UNDERVOLTAGE_FLAG])
      else $error("Undervoltage flag not set.");
   pfault_set_a: assert property (q_ff.evt_s2[FLAG_PFAULT] |=> q_ff.flags[FLAG_PFAULT][*1])
      else $error("Power fault flag not set.");
   ctemp_set_a: assert property (q_ff.evt_s2[FLAG_CTEMP] ##1 wr_shdn |-> q_ff.flags[FLAG_CTEMP])
      else $error("Critical temperature flag lost.");
   shdn_pulse_a: assert property ((q_ff.flags & ~$past(q_ff.flags)) != 3'h0 |-> q_ff.shdn_set)
      else $error("Shutdown indicator not raised with flag.");
   reg2_write_a: assert property (wr_stb && ptr == ADDR_REG2_CTRL |=> q_ff.reg2 == $past(wr_data))
      else $error("Regulator two register did not take write.");
   sleep_copy_a: assert property (sleep_entry && q_ff.r3slp[CTRL_BIT] |=>
      (q_ff.r3vid >> 1) == ($past(q_ff.r3slp) >> 1))
      else $error("Sleep code not copied on sleep entry.");
   sleep_block_a: assert property (!q_ff.r3slp[CTRL_BIT] && !wr_stb |=> $stable(q_ff.r3vid))
      else $error("Voltage code changed with sleep disabled.");
   w0_hold_a: assert property (wr_shdn && wr_data[FLAG_SUPPLY_UNDERVOLTAGE_FLAG:FLAG_CTEMP] == 3'h0 |=>
      (q_ff.flags & $past(q_ff.flags)) == $past(q_ff.flags))
      else $error("Write of zero disturbed a shutdown flag.");
   // The reverse checks catch logic that does too much, which the checks above would miss.
   shdn_only_a: assert property (q_ff.shdn_set |->
      (q_ff.flags & ~$past(q_ff.flags)) != 3'h0)
      else $error("Shutdown indicator raised with no new flag.");
   flag_keep_a: assert property (clr_mask == 3'h0 |=>
      (q_ff.flags & $past(q_ff.flags)) == $past(q_ff.flags))
      else $error("Shutdown flag fell without a host clear.");
   vid_keep_a: assert property (!wr_stb && !sleep_entry |=> $stable(q_ff.r3vid))
      else $error("Regulator three code changed with no write or sleep entry.");
   strap_hold_a: assert property (q_ff.sel_done |=> $stable(q_ff.sel_cap))
      else $error("Sleep pin choice changed after capture.");

endmodule
`default_nettype wire

// ==== pkg/pmsr_pkg.sv ====
// Shared constants and types for the shutdown-source and voltage-ID register slice.
// Assumes a single 125 MHz clock and a synchronous, active-high reset.
package pmsr_pkg;

   // Register offsets on the serial register port.
   localparam logic [7:0] ADDR_SHUTDOWN   = 8'h05;
   localparam logic [7:0] ADDR_REG2_CTRL  = 8'h21;
   localparam logic [7:0] ADDR_REG3_DECAY = 8'h22;
   localparam logic [7:0] ADDR_REG3_VID   = 8'h23;
   localparam logic [7:0] ADDR_REG3_SLEEP = 8'h24;

   // Reset values.
   localparam logic [2:0] RST_SHUTDOWN_FLAGS = 3'h0;
   localparam logic [7:0] RST_REG2_CTRL      = 8'h50;
   localparam logic [7:0] RST_REG3_DECAY     = 8'h70;
   localparam logic [7:0] RST_REG3_VID       = 8'h70;
   localparam logic [7:0] RST_REG3_SLEEP     = 8'h70;

   // Field positions.
   localparam int FLAG_CTEMP    = 0;
   localparam int FLAG_PFAULT   = 1;
   localparam int FLAG_SUPPLY_UNDERVOLTAGE_FLAG     = 2;
   localparam int FLAG_COLD_OFF = 3;
   localparam int CODE_MSB      = 7;
   localparam int CODE_LSB      = 1;
   localparam int CTRL_BIT      = 0;

   // Read value of any unmapped offset.
   localparam logic [7:0] READ_UNMAPPED = 8'h00;

   // Serial port constants; the device address is arbitrary.
   localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h2E;
   localparam logic [3:0] BITS_PER_BYTE    = 4'h8;

   // Serial slave states and the meaning of the byte being received.
   typedef enum logic [2:0] {
      ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_TACK, ST_TLOAD
   } pmsr_i2c_st_t;

   typedef enum logic [1:0] {
      K_ADDR, K_PTR, K_DATA
   } pmsr_kind_t;

endpackage

// ==== src/pmsr_i2c_slave.sv ====
// Byte-level serial register port slave with a register pointer that auto-increments.
// Assumes scl_in and sda_in are raw pins; the caller resolves the open-drain wire.
`timescale 1ns/1ps
`default_nettype none
module pmsr_i2c_slave
   import pmsr_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEFAULT
) (
   // Clock and reset.
   input  wire logic       ref_clk_in,
   input  wire logic       rst_in,
   // Serial pins.
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   output logic            sda_oe_out,
   // Register side.
   input  wire logic [7:0] rd_data_in,
   output logic [7:0]      ptr_out,
   output logic            wr_stb_out,
   output logic [7:0]      wr_data_out
);

   typedef struct packed {
      logic         scl_s1;
      logic         scl_s2;
      logic         scl_q;
      logic         sda_s1;
      logic         sda_s2;
      logic         sda_q;
      pmsr_i2c_st_t st;
      pmsr_kind_t   kind;
      logic         rw;
      logic [3:0]   cnt;
      logic [7:0]   sh;
      logic [7:0]   ptr;
      logic         oe;
      logic         wr;
      logic [7:0]   wd;
   } pmsr_i2c_q_t;

   pmsr_i2c_q_t q_ff;
   pmsr_i2c_q_t nxt_q;
   logic        scl_rise;
   logic        scl_fall;
   logic        bus_start;
   logic        bus_stop;

   // Edges and bus conditions look only at the second and third stages of the synchronisers.
   assign scl_rise  = q_ff.scl_s2 & ~q_ff.scl_q;
   assign scl_fall  = ~q_ff.scl_s2 & q_ff.scl_q;
   assign bus_start = q_ff.scl_s2 & q_ff.scl_q & q_ff.sda_q & ~q_ff.sda_s2;
   assign bus_stop  = q_ff.scl_s2 & q_ff.scl_q & ~q_ff.sda_q & q_ff.sda_s2;

   // Next state; data is sampled on rising clock edges and driven after falling ones.
   always_comb begin
      nxt_q        = q_ff;
      nxt_q.wr     = 1'b0;
      // The pointer steps one cycle after a write strobe, so the strobe still sees its own offset.
      if (q_ff.wr) begin
         nxt_q.ptr = q_ff.ptr + 8'h01;
      end
      nxt_q.scl_s1 = scl_in;
      nxt_q.scl_s2 = q_ff.scl_s1;
      nxt_q.scl_q  = q_ff.scl_s2;
      nxt_q.sda_s1 = sda_in;
      nxt_q.sda_s2 = q_ff.sda_s1;
      nxt_q.sda_q  = q_ff.sda_s2;
      if (bus_start) begin
         nxt_q.st   = ST_RX;
         nxt_q.kind = K_ADDR;
         nxt_q.cnt  = 4'h0;
         nxt_q.oe   = 1'b0;
      end else if (bus_stop) begin
         nxt_q.st = ST_IDLE;
         nxt_q.oe = 1'b0;
      end else begin
         case (q_ff.st)
            ST_RX: begin
               if (scl_rise && q_ff.cnt < BITS_PER_BYTE) begin
                  nxt_q.sh  = {q_ff.sh[6:0], q_ff.sda_s2};
                  nxt_q.cnt = q_ff.cnt + 4'h1;
               end else if (scl_fall && q_ff.cnt == BITS_PER_BYTE) begin
                  nxt_q.oe = 1'b1;
                  nxt_q.st = ST_ACK;
                  case (q_ff.kind)
                     K_ADDR: begin
                        nxt_q.rw = q_ff.sh[0];
                        if (q_ff.sh[7:1] != DEV_ADDR) begin
                           nxt_q.oe = 1'b0;
                           nxt_q.st = ST_IDLE;
                        end
                     end
                     K_PTR: begin
                        nxt_q.ptr = q_ff.sh;
                     end
                     default: begin
                        nxt_q.wr  = 1'b1;
                        nxt_q.wd  = q_ff.sh;
                     end
                  endcase
               end
            end
            ST_ACK, ST_TLOAD: begin
               if (scl_fall) begin
                  if (q_ff.rw) begin
                     nxt_q.sh  = rd_data_in;
                     nxt_q.oe  = ~rd_data_in[7];
                     nxt_q.cnt = 4'h1;
                     nxt_q.ptr = q_ff.ptr + 8'h01;
                     nxt_q.st  = ST_TX;
                  end else begin
                     nxt_q.oe   = 1'b0;
                     nxt_q.cnt  = 4'h0;
                     nxt_q.st   = ST_RX;
                     nxt_q.kind = (q_ff.kind == K_ADDR) ? K_PTR : K_DATA;
                  end
               end
            end
            ST_TX: begin
               if (scl_fall) begin
                  if (q_ff.cnt == BITS_PER_BYTE) begin
                     nxt_q.oe = 1'b0;
                     nxt_q.st = ST_TACK;
                  end else begin
                     nxt_q.sh  = {q_ff.sh[6:0], 1'b1};
                     nxt_q.oe  = ~q_ff.sh[6];
                     nxt_q.cnt = q_ff.cnt + 4'h1;
                  end
               end
            end
            ST_TACK: begin
               // A not-acknowledge from the host ends the read burst.
               if (scl_rise) begin
                  nxt_q.st = q_ff.sda_s2 ? ST_IDLE : ST_TLOAD;
               end
            end
            default: begin
               nxt_q.st = ST_IDLE;
            end
         endcase
      end
   end

   // State register.
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         // Synchronisers start at the idle level of the released bus, so no false edge follows.
         q_ff        <= '0;
         q_ff.scl_s1 <= 1'b1;
         q_ff.scl_s2 <= 1'b1;
         q_ff.scl_q  <= 1'b1;
         q_ff.sda_s1 <= 1'b1;
         q_ff.sda_s2 <= 1'b1;
         q_ff.sda_q  <= 1'b1;
      end else begin
         q_ff <= nxt_q;
      end
   end

   // Outputs straight from the state register.
   assign sda_oe_out  = q_ff.oe;
   assign ptr_out     = q_ff.ptr;
   assign wr_stb_out  = q_ff.wr;
   assign wr_data_out = q_ff.wd;

endmodule
`default_nettype wire

// ==== testbench/pmsr_i2c_host.sv ====
// I2C host model for the register port of the shutdown and VID slice.
// Assumes the bench resolves SDA from both parties, taking the slave's level while the slave drives.
`timescale 1ns/1ps
`default_nettype none
module pmsr_i2c_host
   import pmsr_pkg::*;
#(
   parameter int HALF = 10
) (
   // Clock and bus pins.
   input  wire logic ref_clk_in,
   input  wire logic sda_in,
   output logic      scl_out,
   output logic      sda_out
);
   // Idle bus has both lines released high.
   initial begin
      scl_out = 1'b1;
      sda_out = 1'b1;
   end
   // Pins change only on falling clock edges.
   task automatic hc(input int n);
      repeat (n) @(negedge ref_clk_in);
   endtask
   // Data moves 4 cycles after SCL falls so the slave never sees a false start.
   task automatic put_bit(input logic b);
      sda_out = b;
      hc(HALF);
      scl_out = 1'b1;
      hc(HALF);
      scl_out = 1'b0;
      hc(4);
   endtask
   // Releases SDA and samples the wire in mid-high.
   task automatic get_bit(output logic b);
      sda_out = 1'b1;
      hc(HALF);
      scl_out = 1'b1;
      hc(HALF / 2);
      b = sda_in;
      hc(HALF / 2);
      scl_out = 1'b0;
      hc(4);
   endtask
   // Start or repeated start.
   task automatic start_c;
      sda_out = 1'b1;
      hc(HALF);
      scl_out = 1'b1;
      hc(HALF);
      sda_out = 1'b0;
      hc(HALF);
      scl_out = 1'b0;
      hc(4);
   endtask
   // Stop returns the bus to idle.
   task automatic stop_c;
      sda_out = 1'b0;
      hc(HALF);
      scl_out = 1'b1;
      hc(HALF);
      sda_out = 1'b1;
      hc(HALF);
   endtask
   // One byte out, MSB first, then the slave's acknowledge.
   task automatic put_byte(input logic [7:0] b, output logic ok);
      logic a;
      for (int i = 7; i >= 0; i--) put_bit(b[i]);
      get_bit(a);
      ok = ~a;
   endtask
   // One byte in; last selects NACK to end the burst.
   task automatic get_byte(input logic last, output logic [7:0] b);
      logic x;
      for (int i = 7; i >= 0; i--) begin
         get_bit(x);
         b[i] = x;
      end
      put_bit(last);
   endtask
   // Register write: address, pointer, one data byte.
   task automatic wr_reg(input logic [6:0] dev, input logic [7:0] a, input logic [7:0] d,
                         output logic ok);
      logic k0, k1, k2;
      start_c();
      put_byte({dev, 1'b0}, k0);
      put_byte(a, k1);
      put_byte(d, k2);
      stop_c();
      ok = k0 & k1 & k2;
   endtask
   // Register read through pointer write and repeated start.
   task automatic rd_reg(input logic [6:0] dev, input logic [7:0] a, output logic [7:0] d,
                         output logic ok);
      logic k0, k1, k2;
      start_c();
      put_byte({dev, 1'b0}, k0);
      put_byte(a, k1);
      start_c();
      put_byte({dev, 1'b1}, k2);
      get_byte(1'b1, d);
      stop_c();
      ok = k0 & k1 & k2;
   endtask
endmodule
`default_nettype wire

// ==== testbench/test_pmsr_shutdown_vid_regs.sv ====
// Self-checking bench for the shutdown-source and voltage-ID register slice.
// Assumes the host model pmsr_i2c_host; pin A is strapped first, pin B after the mid-run reset.
`timescale 1ns/1ps
`default_nettype none
module test_pmsr_shutdown_vid_regs;
   import pmsr_pkg::*;
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdat;
      logic [7:0] rexp;
   } pmsr_row_t;
   localparam int LIMIT = 60000;
   // Bench signals.
   logic       ref_clk_in = 1'b0;
   logic       rst_in = 1'b1;
   logic       scl, host_sda, sda_oe, sda_o, pulse, r2d, r3d, ok;
   logic       supply_undervoltage_flag = 1'b0, pflt = 1'b0, ctemp = 1'b0, pin_a = 1'b0, pin_b = 1'b0;
   logic       strap = 1'b0;
   logic [6:0] r2c, r3c;
   logic [7:0] e21, e22, e23, d;
   int         n_fail = 0, samples_checked = 0, n_pulse = 0, p0, cyc = 0;
   wire        sda_wire = sda_oe ? sda_o : host_sda;
   pmsr_row_t  rows [9] = '{
      '{ADDR_REG2_CTRL, 8'hAA, 8'hAA}, '{ADDR_REG2_CTRL, 8'h01, 8'h01},
      '{ADDR_REG3_DECAY, 8'hFF, 8'hFF}, '{ADDR_REG3_DECAY, 8'h00, 8'h00},
      '{ADDR_REG3_VID, 8'h81, 8'h81}, '{ADDR_REG3_SLEEP, 8'h5A, 8'h5A},
      '{ADDR_SHUTDOWN, 8'hFF, 8'h00}, '{8'h30, 8'h77, 8'h00},
      '{ADDR_REG3_VID, 8'hFE, 8'hFE}};
   pmsr_shutdown_vid_regs i_pmsr_shutdown_vid_regs (
      .ref_clk_in(ref_clk_in), .rst_in(rst_in), .scl_in(scl), .sda_in(sda_wire),
      .sda_out(sda_o), .sda_oe_out(sda_oe), .supply_undervoltage_flag_shutdown_in(supply_undervoltage_flag),
      .power_fault_shutdown_in(pflt), .crit_temp_shutdown_in(ctemp),
      .sleep_control_pin_a_in(pin_a), .sleep_control_pin_b_in(pin_b),
      .sleep_pin_select_in(strap), .shutdown_indicator_set_out(pulse),
      .reg2_voltage_code_out(r2c), .reg2_decay_select_out(r2d),
      .reg3_voltage_code_out(r3c), .reg3_decay_select_out(r3d));
   pmsr_i2c_host i_pmsr_i2c_host (
      .ref_clk_in(ref_clk_in), .sda_in(sda_wire), .scl_out(scl), .sda_out(host_sda));
   // 125 MHz clock.
   always #4 ref_clk_in = ~ref_clk_in;
   // Counts indicator pulses and cuts a hang short.
   always @(posedge ref_clk_in) begin
      cyc <= cyc + 1;
      if (pulse === 1'b1) n_pulse <= n_pulse + 1;
      if (cyc == LIMIT) begin
         n_fail = n_fail + 1;
         wrap_up();
      end
   end
   // Prints the counts and the verdict, then stops.
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic idle(input int n);
      repeat (n) @(negedge ref_clk_in);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      i_pmsr_i2c_host.wr_reg(DEV_ADDR_DEFAULT, a, v, ok);
      chk("write_ack", {7'h00, ok}, 8'h01);
   endtask
   task automatic rd(input string nm, input logic [7:0] a, input logic [7:0] v);
      i_pmsr_i2c_host.rd_reg(DEV_ADDR_DEFAULT, a, d, ok);
      chk(nm, d, v);
   endtask
   // Regulator outputs against the expected register images.
   task automatic outs;
      chk("reg2_voltage_code", {1'b0, r2c}, {1'b0, e21[7:1]});
      chk("reg2_decay_select", {7'h00, r2d}, {7'h00, e21[0]});
      chk("reg3_voltage_code", {1'b0, r3c}, {1'b0, e23[7:1]});
      chk("reg3_decay_select", {7'h00, r3d}, {7'h00, e22[0]});
   endtask
   // Reset for 8 cycles, then leave the synchronisers time to fill.
   task automatic rst_seq;
      rst_in = 1'b1;
      idle(8);
      rst_in = 1'b0;
      idle(6);
      e21 = 8'h50;
      e22 = 8'h70;
      e23 = 8'h70;
   endtask
   // Main sequence.
   initial begin
      rst_seq();
      outs();
      foreach (rows[i]) begin
         wr(rows[i].addr, rows[i].wdat);
         rd("readback", rows[i].addr, rows[i].rexp);
         if (rows[i].addr == ADDR_REG2_CTRL) e21 = rows[i].rexp;
         if (rows[i].addr == ADDR_REG3_DECAY) e22 = rows[i].rexp;
         if (rows[i].addr == ADDR_REG3_VID) e23 = rows[i].rexp;
         outs();
      end
      $display("test register rows done");
      i_pmsr_i2c_host.wr_reg(7'h2F, ADDR_REG2_CTRL, 8'h00, ok);
      chk("foreign_ack", {7'h00, ok}, 8'h00);
      outs();
      $display("test foreign address done");
      // Each cause alone: one pulse, a zero write keeps it, a one write clears it.
      for (int k = 0; k < 3; k++) begin
         p0 = n_pulse;
         {supply_undervoltage_flag, pflt, ctemp} = 3'h4 >> k;
         idle(6);
         {supply_undervoltage_flag, pflt, ctemp} = 3'h0;
         idle(4);
         chk("pulses", 8'(n_pulse - p0), 8'h01);
         rd("flag_set", ADDR_SHUTDOWN, 8'h04 >> k);
         wr(ADDR_SHUTDOWN, 8'hF0);
         rd("flag_kept", ADDR_SHUTDOWN, 8'h04 >> k);
         wr(ADDR_SHUTDOWN, 8'h04 >> k);
         rd("flag_clear", ADDR_SHUTDOWN, 8'h00);
      end
      // A cause still high wins over the clear.
      {supply_undervoltage_flag, pflt, ctemp} = 3'h7;
      idle(6);
      rd("all_flags", ADDR_SHUTDOWN, 8'h07);
      wr(ADDR_SHUTDOWN, 8'h0F);
      rd("set_wins", ADDR_SHUTDOWN, 8'h07);
      {supply_undervoltage_flag, pflt, ctemp} = 3'h0;
      wr(ADDR_SHUTDOWN, 8'h0F);
      rd("all_clear", ADDR_SHUTDOWN, 8'h00);
      $display("test shutdown flags done");
      // Sleep copy on the strapped pin only, and only when enabled.
      wr(ADDR_REG3_SLEEP, 8'h3B);
      wr(ADDR_REG3_VID, 8'h70);
      e23 = 8'h70;
      pin_b = 1'b1;
      idle(8);
      pin_b = 1'b0;
      outs();
      pin_a = 1'b1;
      idle(8);
      pin_a = 1'b0;
      e23 = 8'h3A;
      outs();
      rd("sleep_copy", ADDR_REG3_VID, 8'h3A);
      wr(ADDR_REG3_SLEEP, 8'h50);
      wr(ADDR_REG3_VID, 8'h70);
      e23 = 8'h70;
      pin_a = 1'b1;
      idle(8);
      pin_a = 1'b0;
      outs();
      $display("test sleep copy done");
      // Mid-run reset with a flag set returns every register to its reset value.
      // The strap moves to pin B here; it only takes effect at the next reset.
      ctemp = 1'b1;
      strap = 1'b1;
      idle(6);
      ctemp = 1'b0;
      rst_seq();
      outs();
      rd("rst_05", ADDR_SHUTDOWN, 8'h00);
      rd("rst_21", ADDR_REG2_CTRL, 8'h50);
      rd("rst_22", ADDR_REG3_DECAY, 8'h70);
      rd("rst_23", ADDR_REG3_VID, 8'h70);
      rd("rst_24", ADDR_REG3_SLEEP, 8'h70);
      $display("test reset values done");
      // With pin B strapped, pin A is ignored and pin B triggers the copy.
      wr(ADDR_REG3_SLEEP, 8'h3B);
      pin_a = 1'b1;
      idle(8);
      pin_a = 1'b0;
      outs();
      pin_b = 1'b1;
      idle(8);
      pin_b = 1'b0;
      e23 = 8'h3A;
      outs();
      rd("pin_b_copy", ADDR_REG3_VID, 8'h3A);
      $display("test pin b strap done");
      wrap_up();
   end
endmodule
`default_nettype wire
